// file: common/dim_regs.svh
/*
 * Selector codes, terminal defaults and timing counts for the
 * digital input function mapper. Assumes a 250 MHz system clock.
 */
`ifndef DIM_REGS_SVH
`define DIM_REGS_SVH

`define DIM_CLK_MHZ        250
`define DIM_PULSE_MIN_MS   14
`define DIM_PULSE_MIN_CYC  (`DIM_PULSE_MIN_MS * 1000 * `DIM_CLK_MHZ)

`define DIM_CODE_NONE      6'h00
`define DIM_CODE_RESET     6'h01
`define DIM_CODE_COAST     6'h02
`define DIM_CODE_RSTCOAST  6'h03
`define DIM_CODE_QSTOP     6'h04
`define DIM_CODE_DCHALT    6'h05
`define DIM_CODE_STOP      6'h06
`define DIM_CODE_START     6'h07
`define DIM_CODE_LSTART    6'h08
`define DIM_CODE_REV       6'h09
`define DIM_CODE_STARTREV  6'h0A
`define DIM_CODE_FWD       6'h0B
`define DIM_CODE_BWD       6'h0C
`define DIM_CODE_JOG       6'h0D
`define DIM_CODE_FRZREF    6'h0E
`define DIM_CODE_FRZOUT    6'h0F
`define DIM_CODE_SPDUP     6'h10
`define DIM_CODE_SPDDN     6'h11
`define DIM_CODE_CATCH     6'h13
`define DIM_CODE_SLOW      6'h14
`define DIM_CODE_RAMP2     6'h15
`define DIM_CODE_PRE_LSB   6'h16
`define DIM_CODE_PRE_MSB   6'h17
`define DIM_CODE_PRE_ON    6'h18
`define DIM_CODE_ACC_HALT  6'h1A
`define DIM_CODE_ACC_SS    6'h1B
`define DIM_CODE_PULSEREF  6'h1C
`define DIM_CODE_PULSEFB   6'h1D
`define DIM_CODE_PULSEIN   6'h1E
`define DIM_CODE_SET_LSB   6'h1F
`define DIM_CODE_SET_MSB   6'h20
`define DIM_CODE_RSTSTART  6'h21
`define DIM_CODE_ENCREF    6'h22
`define DIM_CODE_ENCIN     6'h24

`define DIM_DEF_SEL0       6'h07
`define DIM_DEF_SEL1       6'h09
`define DIM_DEF_SEL2       6'h03
`define DIM_DEF_SEL3       6'h0D
`define DIM_DEF_SEL4       6'h00

`endif

// file: common/dim_pkg.sv
/*
 * Types for the digital input function mapper.
 * Assumes five terminals with six-bit selector codes.
 */
package dim_pkg;
	typedef logic [5:0] dim_code_t;

	typedef struct packed {
		logic coast;
		logic quickStop;
		logic dcBrake;
		logic rampStop;
		logic run;
		logic reverse;
		logic onlyForward;
		logic onlyBackward;
		logic fixedSpeed;
		logic freezeRef;
		logic freezeOut;
		logic alarmClear;
	} dim_cmd_t;

	typedef struct packed {
		logic speedUp;
		logic speedDown;
		logic catchUp;
		logic slowDown;
		logic ramp2;
		logic presetLsb;
		logic presetMsb;
		logic presetOn;
		logic setupLsb;
		logic setupMsb;
		logic accurateHalt;
		logic accurateStartStop;
		logic resetStart;
	} dim_aux_t;
endpackage

// file: verilog/dim_input_cond.sv
/*
 * Input conditioner for one terminal: two-stage synchroniser, edge
 * pulses and a high/low width qualifier. Assumes pins synchronous-ish.
 */
module dim_input_cond #(
	parameter int MIN_CYC = 3500000
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// terminal
	input  wire logic pin,
	// conditioned outputs
	output logic      level,
	output logic      rise,
	output logic      fall,
	output logic      longHighPulse
);
	logic        stage1;
	logic        stage2;
	logic [31:0] widthCount;
	logic        lowSeen;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			level  <= 1'b0;
		end else begin
			stage1 <= pin;
			stage2 <= stage1;
			level  <= stage2;
		end
	end

	assign rise = stage2 & ~level;
	assign fall = ~stage2 & level;

	// pulse qualifies once high long enough after a long enough low
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			widthCount    <= 32'h00000000;
			lowSeen       <= 1'b0;
			longHighPulse <= 1'b0;
		end else begin
			longHighPulse <= 1'b0;
			if (rise || fall) begin
				if (fall && widthCount >= 32'(MIN_CYC))
					lowSeen <= 1'b0;
				if (rise)
					lowSeen <= lowSeen | (widthCount >= 32'(MIN_CYC));
				widthCount <= 32'h00000000;
			end else begin
				if (widthCount != 32'hFFFFFFFF)
					widthCount <= widthCount + 32'h00000001;
				if (level && widthCount == 32'(MIN_CYC) - 32'h00000001) begin
					longHighPulse <= lowSeen;
					lowSeen       <= 1'b0;
				end
				if (!level && widthCount == 32'(MIN_CYC) - 32'h00000001)
					lowSeen <= 1'b1;
			end
		end
	end
endmodule

// file: verilog/dim_mapper.sv
/*
 * Digital input function mapper: five terminals, each with a selector,
 * mapped to drive commands for ramp, brake and output stage.
 * Assumes selectors, parameters and mode bits come from outside.
 */
// What this block does
// - each of five inputs has its own function selector
// - code 0 ignores the input entirely
// - code 1 rising edge clears alarm; trip-locked alarms need power cycle
// - code 2 low level disables output stage, motor coasts
// - code 3 low coasts; falling edge also clears alarm
// - code 4 low starts quick-stop ramp down
// - code 5 low applies DC braking only if time and voltage nonzero
// - code 6 low ramps down using selected ramp
// - code 7 level start: high runs, low stops
// - code 8 starts on high pulse of 14 ms if no stop present
// - code 9 high reverses without start; ignored in closed loop
// - code 10 starts and reverses; ignored in closed loop
// - codes 11 and 12 start restricted clockwise or anticlockwise
// - code 13 forces jog frequency unless coast, quick stop or DC brake
// - code 14 freezes reference, kept over stop and mains loss
// - code 15 freezes output frequency, changed only by speed pulses
// - codes 16 to 33 pass to the reference and setup logic
// - precise, pulse and encoder codes only on allowed terminals
// - pulse codes refused on fourth input when pulse output active
// - defaults are start, reversing, reset-coast, jog, none
// - speed pulse 14 ms low, then 14 ms high, steps by one unit
// - while output frozen only coast, quick stop, DC brake stop
`include "dim_regs.svh"

module dim_mapper #(
	parameter int NUM_IN  = 5,
	parameter int MIN_CYC = `DIM_PULSE_MIN_CYC
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	// terminals
	input  wire logic [NUM_IN-1:0]    terminal,
	// configuration
	input  wire logic                 factoryReset,
	input  wire logic                 selectorWrite,
	input  wire logic [2:0]           selectorIndex,
	input  wire dim_pkg::dim_code_t   selectorCode,
	input  wire logic                 closedLoop,
	input  wire logic                 pulseOutputSel,
	input  wire logic                 dcTimeNonzero,
	input  wire logic                 dcVoltNonzero,
	input  wire logic                 tripLocked,
	// status
	output dim_pkg::dim_code_t        selector [NUM_IN],
	output logic                      selectorRejected,
	// commands
	output dim_pkg::dim_cmd_t         cmd,
	output dim_pkg::dim_aux_t         aux,
	output logic                      stepUp,
	output logic                      stepDown
);
	logic [NUM_IN-1:0] level;
	logic [NUM_IN-1:0] rise;
	logic [NUM_IN-1:0] fall;
	logic [NUM_IN-1:0] longPulse;
	logic              latchedRun;
	dim_pkg::dim_cmd_t next_cmd;
	dim_pkg::dim_aux_t next_aux;
	logic              next_stepUp;
	logic              next_stepDown;

	genvar g;
	generate
		for (g = 0; g < NUM_IN; g++) begin : gen_in
			dim_input_cond #(
				.MIN_CYC (MIN_CYC)
			) u_cond (
				.sys_clk       (sys_clk),
				.resetn        (resetn),
				.pin           (terminal[g]),
				.level         (level[g]),
				.rise          (rise[g]),
				.fall          (fall[g]),
				.longHighPulse (longPulse[g])
			);
		end
	endgenerate

	function automatic dim_pkg::dim_code_t defaultCode(input int idx);
		unique case (idx)
			0:       defaultCode = `DIM_DEF_SEL0;
			1:       defaultCode = `DIM_DEF_SEL1;
			2:       defaultCode = `DIM_DEF_SEL2;
			3:       defaultCode = `DIM_DEF_SEL3;
			default: defaultCode = `DIM_DEF_SEL4;
		endcase
	endfunction

	// which codes a terminal may take
	function automatic logic codeAllowed(input int idx, input dim_pkg::dim_code_t c,
			input logic pulseOut);
		logic lastTwo;
		lastTwo = (idx >= NUM_IN - 2);
		if (c == 6'h12 || c == 6'h19 || c > 6'h24)
			codeAllowed = 1'b0;
		else if (c == `DIM_CODE_ACC_HALT || c == `DIM_CODE_ACC_SS)
			codeAllowed = (idx < 2);
		else if (c == `DIM_CODE_PULSEREF || c == `DIM_CODE_PULSEFB)
			codeAllowed = lastTwo && !(idx == NUM_IN - 2 && pulseOut);
		else if (c == `DIM_CODE_PULSEIN)
			codeAllowed = (idx == NUM_IN - 1);
		else if (c >= `DIM_CODE_ENCREF)
			codeAllowed = lastTwo;
		else
			codeAllowed = 1'b1;
	endfunction

	// selector store
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_IN; i++)
				selector[i] <= defaultCode(i);
			selectorRejected <= 1'b0;
		end else if (factoryReset) begin
			for (int i = 0; i < NUM_IN; i++)
				selector[i] <= defaultCode(i);
			selectorRejected <= 1'b0;
		end else if (selectorWrite) begin
			if (int'(selectorIndex) < NUM_IN &&
					codeAllowed(int'(selectorIndex), selectorCode, pulseOutputSel)) begin
				selector[selectorIndex] <= selectorCode;
				selectorRejected        <= 1'b0;
			end else begin
				selectorRejected <= 1'b1;
			end
		end
	end

	// command decode
	always_comb begin
		logic anyStop;
		logic anyStart;
		logic startHigh;
		logic startRev;
		logic lstartPulse;
		anyStop       = 1'b0;
		anyStart      = 1'b0;
		startHigh     = 1'b0;
		startRev      = 1'b0;
		lstartPulse   = 1'b0;
		next_cmd      = '0;
		next_aux      = '0;
		next_stepUp   = 1'b0;
		next_stepDown = 1'b0;
		for (int i = 0; i < NUM_IN; i++) begin
			unique case (selector[i])
				`DIM_CODE_NONE:     ;
				`DIM_CODE_RESET:    next_cmd.alarmClear |= rise[i] & ~tripLocked;
				`DIM_CODE_COAST:    next_cmd.coast |= ~level[i];
				`DIM_CODE_RSTCOAST: begin
					next_cmd.coast      |= ~level[i];
					next_cmd.alarmClear |= fall[i] & ~tripLocked;
				end
				`DIM_CODE_QSTOP:    next_cmd.quickStop |= ~level[i];
				`DIM_CODE_DCHALT:
					next_cmd.dcBrake |= ~level[i] & dcTimeNonzero & dcVoltNonzero;
				`DIM_CODE_STOP:     anyStop |= ~level[i];
				`DIM_CODE_START:    startHigh |= level[i];
				`DIM_CODE_LSTART:   lstartPulse |= longPulse[i];
				`DIM_CODE_REV:      next_cmd.reverse |= level[i] & ~closedLoop;
				`DIM_CODE_STARTREV: startRev |= level[i] & ~closedLoop;
				`DIM_CODE_FWD: begin
					startHigh |= level[i];
					next_cmd.onlyForward |= level[i];
				end
				`DIM_CODE_BWD: begin
					startHigh |= level[i];
					next_cmd.onlyBackward |= level[i];
				end
				`DIM_CODE_JOG:      next_cmd.fixedSpeed |= level[i];
				`DIM_CODE_FRZREF:   next_cmd.freezeRef |= level[i];
				`DIM_CODE_FRZOUT:   next_cmd.freezeOut |= level[i];
				`DIM_CODE_SPDUP:    next_stepUp |= longPulse[i];
				`DIM_CODE_SPDDN:    next_stepDown |= longPulse[i];
				`DIM_CODE_CATCH:    next_aux.catchUp |= level[i];
				`DIM_CODE_SLOW:     next_aux.slowDown |= level[i];
				`DIM_CODE_RAMP2:    next_aux.ramp2 |= level[i];
				`DIM_CODE_PRE_LSB:  next_aux.presetLsb |= level[i];
				`DIM_CODE_PRE_MSB:  next_aux.presetMsb |= level[i];
				`DIM_CODE_PRE_ON:   next_aux.presetOn |= level[i];
				`DIM_CODE_ACC_HALT: begin
					next_aux.accurateHalt |= ~level[i];
					anyStop |= ~level[i];
				end
				`DIM_CODE_ACC_SS:   begin
					next_aux.accurateStartStop |= level[i];
					startHigh |= level[i];
				end
				`DIM_CODE_SET_LSB:  next_aux.setupLsb |= level[i];
				`DIM_CODE_SET_MSB:  next_aux.setupMsb |= level[i];
				`DIM_CODE_RSTSTART: begin
					next_aux.resetStart |= level[i];
					startHigh |= level[i];
					next_cmd.alarmClear |= rise[i] & ~tripLocked;
				end
				default:            ;
			endcase
		end
		// down/up steps only act while something is frozen
		next_stepUp   &= next_cmd.freezeRef | next_cmd.freezeOut;
		next_stepDown &= next_cmd.freezeRef | next_cmd.freezeOut;
		// speed down wins when both are pulsed
		next_stepUp &= ~next_stepDown;
		// reversing-start conflicts with any other start
		anyStart = startHigh | latchedRun | lstartPulse;
		if (startRev && !anyStart) begin
			next_cmd.reverse = 1'b1;
			anyStart         = 1'b1;
		end
		if (next_cmd.freezeOut)
			anyStop = 1'b0;
		next_aux.accurateHalt &= ~next_cmd.freezeOut;
		next_cmd.rampStop = anyStop & ~next_cmd.freezeOut;
		next_cmd.run = anyStart & ~anyStop & ~next_cmd.coast & ~next_cmd.quickStop
			& ~next_cmd.dcBrake;
		if (next_cmd.coast || next_cmd.quickStop || next_cmd.dcBrake)
			next_cmd.fixedSpeed = 1'b0;
	end

	// latched start holds until a stop
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			latchedRun <= 1'b0;
		else if (next_cmd.rampStop || next_cmd.coast || next_cmd.quickStop ||
				next_cmd.dcBrake)
			latchedRun <= 1'b0;
		else if (|longPulse && !next_cmd.rampStop) begin
			for (int i = 0; i < NUM_IN; i++)
				if (selector[i] == `DIM_CODE_LSTART && longPulse[i])
					latchedRun <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmd      <= '0;
			aux      <= '0;
			stepUp   <= 1'b0;
			stepDown <= 1'b0;
		end else begin
			cmd      <= next_cmd;
			aux      <= next_aux;
			stepUp   <= next_stepUp;
			stepDown <= next_stepDown;
		end
	end
endmodule

// file: test/dim_mapper_props.sv
/* port checker for dim_mapper
   bound to every dim_mapper, one clock domain */
module dim_mapper_props #(
	parameter int NUM_IN  = 5,
	parameter int MIN_CYC = 20
) (
	input wire logic               sys_clk,
	input wire logic               resetn,
	input wire logic [NUM_IN-1:0]  terminal,
	input wire logic               factoryReset,
	input wire logic               selectorWrite,
	input wire logic [2:0]         selectorIndex,
	input wire dim_pkg::dim_code_t selectorCode,
	input wire logic               pulseOutputSel,
	input wire logic               dcVoltNonzero,
	input wire logic               tripLocked,
	input wire dim_pkg::dim_code_t selector [NUM_IN],
	input wire logic               selectorRejected,
	input wire dim_pkg::dim_cmd_t  cmd,
	input wire logic               stepUp,
	input wire logic               stepDown
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire wr = selectorWrite && !factoryReset;
	chk_write_lands: assert property (wr && selectorIndex == 3'h0 && selectorCode == 6'h07
		|=> selector[0] == 6'h07 && !selectorRejected) else $error("write lost");
	chk_index_refused: assert property (wr && selectorIndex > 3'h4 |=> selectorRejected)
		else $error("bad index taken");
	chk_factory_dflt: assert property (factoryReset |=> selector[0] == 6'h07
		&& selector[1] == 6'h09 && selector[2] == 6'h03 && selector[3] == 6'h0D
		&& selector[4] == 6'h00) else $error("defaults wrong");
	chk_precise_place: assert property (wr && selectorIndex inside {[3'h2:3'h4]}
		&& selectorCode inside {6'h1A, 6'h1B} |=> selectorRejected) else $error("placement");
	chk_pulse_blocked: assert property (wr && selectorIndex == 3'h3 && pulseOutputSel
		&& selectorCode inside {6'h1C, 6'h1D} |=> selectorRejected) else $error("pulse code");
	chk_coast_low: assert property ((selector[1] == 6'h02 && !terminal[1]) [*5]
		|-> cmd.coast) else $error("no coast");
	chk_dc_gated: assert property ((!dcVoltNonzero) [*5] |-> !cmd.dcBrake)
		else $error("brake ungated");
	chk_jog_masked: assert property (cmd.coast || cmd.quickStop || cmd.dcBrake
		|-> !cmd.fixedSpeed) else $error("jog not masked");
	chk_trip_hold: assert property (tripLocked [*5] |-> !cmd.alarmClear)
		else $error("locked clear");
	chk_step_freeze: assert property (stepUp || stepDown |-> cmd.freezeRef || cmd.freezeOut)
		else $error("step unfrozen");
	cover property (cmd.run);
	cover property (stepUp);
	cover property (cmd.alarmClear);
endmodule

bind dim_mapper dim_mapper_props #(.NUM_IN(NUM_IN), .MIN_CYC(MIN_CYC)) props (
	.sys_clk          (sys_clk),
	.resetn           (resetn),
	.terminal         (terminal),
	.factoryReset     (factoryReset),
	.selectorWrite    (selectorWrite),
	.selectorIndex    (selectorIndex),
	.selectorCode     (selectorCode),
	.pulseOutputSel   (pulseOutputSel),
	.dcVoltNonzero    (dcVoltNonzero),
	.tripLocked       (tripLocked),
	.selector         (selector),
	.selectorRejected (selectorRejected),
	.cmd              (cmd),
	.stepUp           (stepUp),
	.stepDown         (stepDown)
);

// file: test/dim_term_model.sv
/* switch model for the five terminals
   levels from the bench, timed pulses on request */
module dim_term_model #(
	parameter int HOLD = 20
) (
	input  wire logic       sys_clk,
	input  wire logic [4:0] lvl,
	input  wire logic [4:0] pls,
	output logic      [4:0] terminal
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial terminal = 5'h00;
	// low then high, each past the minimum width
	always @(posedge sys_clk) begin
		// half a period on, clear of the bench's own drive time
		#2;
		cnt = (pls == 5'h00) ? 0 : cnt + 1;
		terminal = lvl | ((cnt > HOLD + 2 && cnt <= 2 * HOLD + 4) ? pls : 5'h00);
	end
endmodule

// file: test/drive_digital_input_function_mapper_tb_top.sv
/* bench for dim_mapper with a switch model
   short pulse width parameter, fixed seed */
module drive_digital_input_function_mapper_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int H = 20;
	logic               sys_clk = 1'b0;
	logic               resetn = 1'b0;
	logic               factoryReset = 1'b0;
	logic               selectorWrite = 1'b0;
	logic [2:0]         selectorIndex = 3'h0;
	dim_pkg::dim_code_t selectorCode = 6'h00;
	logic               closedLoop = 1'b0;
	logic               pulseOutputSel = 1'b0;
	logic               dcTimeNonzero = 1'b1;
	logic               dcVoltNonzero = 1'b1;
	logic               tripLocked = 1'b0;
	logic [4:0]         lvl = 5'h00;
	logic [4:0]         pls = 5'h00;
	logic [4:0]         terminal;
	dim_pkg::dim_code_t selector [5];
	logic               selectorRejected;
	logic               stepUp;
	logic               stepDown;
	dim_pkg::dim_cmd_t  cmd;
	dim_pkg::dim_aux_t  aux;
	int                 nFail = 0;
	int                 numChecks = 0;
	int                 n;
	int                 i;
	int                 c;
	dim_pkg::dim_code_t e;
	int                 ti [13] = '{5, 2, 1, 3, 3, 2, 3, 4, 2, 3, 0, 0, 0};
	int                 tc [13] = '{7, 26, 27, 28, 29, 28, 30, 30, 34, 36, 18, 25, 37};
	int                 stp [4] = '{2, 4, 5, 6};
	int                 dflt [5] = '{7, 9, 3, 13, 0};

	always #2 sys_clk = ~sys_clk;
	dim_mapper #(.NUM_IN(5), .MIN_CYC(H)) DUT (
		.sys_clk          (sys_clk),
		.resetn           (resetn),
		.terminal         (terminal),
		.factoryReset     (factoryReset),
		.selectorWrite    (selectorWrite),
		.selectorIndex    (selectorIndex),
		.selectorCode     (selectorCode),
		.closedLoop       (closedLoop),
		.pulseOutputSel   (pulseOutputSel),
		.dcTimeNonzero    (dcTimeNonzero),
		.dcVoltNonzero    (dcVoltNonzero),
		.tripLocked       (tripLocked),
		.selector         (selector),
		.selectorRejected (selectorRejected),
		.cmd              (cmd),
		.aux              (aux),
		.stepUp           (stepUp),
		.stepDown         (stepDown)
	);
	dim_term_model #(.HOLD(H)) model (
		.sys_clk  (sys_clk),
		.lvl      (lvl),
		.pls      (pls),
		.terminal (terminal)
	);

	function automatic bit ok(int x, int y, bit p);
		return x < 5 && !(y == 18 || y == 25 || y > 36) && !(y inside {26, 27} && x > 1)
			&& !(y inside {28, 29} && (x < 3 || (x == 3 && p))) && !(y == 30 && x < 4)
			&& !(y > 33 && x < 3);
	endfunction
	task automatic chk(input logic [11:0] s, input logic [11:0] x);
		numChecks++;
		if (s !== x) begin
			nFail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input int x, input int y);
		selectorWrite = 1'b1;
		selectorIndex = x[2:0];
		selectorCode = y[5:0];
		tick(1);
		selectorWrite = 1'b0;
		tick(1);
	endtask
	task automatic hold(input logic [4:0] v);
		lvl = v;
		tick(6);
	endtask
	// counts alarm clear pulses
	task automatic clears(output int k);
		k = 0;
		repeat (10) begin
			tick(1);
			k += cmd.alarmClear;
		end
	endtask
	task automatic closeOut;
		$display("checks %0d failures %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(32'hB5B7));
		tick(2);
		resetn = 1'b1;
		for (i = 0; i < 5; i++) chk(selector[i], dflt[i]);
		for (n = 0; n < 40; n++) begin
			i = (n < 13) ? ti[n] : $urandom % 6;
			c = (n < 13) ? tc[n] : $urandom % 40;
			pulseOutputSel = (n < 13) ? (n == 3) : $urandom % 2;
			e = (i < 5) ? selector[i] : 6'h00;
			if (ok(i, c, pulseOutputSel)) e = c[5:0];
			wr(i, c);
			chk(selectorRejected, !ok(i, c, pulseOutputSel));
			if (i < 5) chk(selector[i], e);
		end
		factoryReset = 1'b1;
		tick(1);
		factoryReset = 1'b0;
		tick(1);
		for (i = 0; i < 5; i++) chk(selector[i], dflt[i]);
		pulseOutputSel = 1'b0;
		for (i = 0; i < 5; i++) wr(i, 0);
		hold(5'h1F);
		chk(cmd, 12'h000);
		wr(0, 7);
		hold(5'h01);
		chk(cmd.run, 1'b1);
		hold(5'h00);
		chk(cmd.run, 1'b0);
		for (c = 9; c < 11; c++) begin
			wr(0, c);
			hold(5'h01);
			chk(cmd[7:6], (c == 10) ? 2'h3 : 2'h1);
			closedLoop = 1'b1;
			hold(5'h01);
			chk(cmd.reverse, 1'b0);
			closedLoop = 1'b0;
		end
		for (c = 11; c < 13; c++) begin
			wr(0, c);
			hold(5'h01);
			chk(cmd[7:4], (c == 11) ? 4'hA : 4'h9);
		end
		wr(0, 0);
		wr(2, 13);
		for (n = 0; n < 4; n++) begin
			wr(1, stp[n]);
			hold(5'h06);
			chk({cmd[11:8], cmd.fixedSpeed}, 5'h01);
			hold(5'h04);
			chk({cmd[11:8], cmd.fixedSpeed}, {4'h8 >> n, n == 3});
		end
		wr(1, 5);
		dcVoltNonzero = 1'b0;
		hold(5'h04);
		chk(cmd.dcBrake, 1'b0);
		dcVoltNonzero = 1'b1;
		wr(1, 0);
		wr(2, 0);
		wr(4, 1);
		lvl = 5'h10;
		clears(n);
		chk(n, 1);
		hold(5'h00);
		tripLocked = 1'b1;
		lvl = 5'h10;
		clears(n);
		chk(n, 0);
		tripLocked = 1'b0;
		wr(4, 3);
		hold(5'h10);
		lvl = 5'h00;
		clears(n);
		chk({n[3:0], cmd.coast}, 5'h03);
		wr(4, 0);
		wr(0, 14);
		wr(1, 16);
		hold(5'h01);
		pls = 5'h02;
		n = 0;
		repeat (3 * H + 8) begin
			tick(1);
			n += stepUp;
		end
		pls = 5'h00;
		chk({n[3:0], cmd.freezeRef}, 5'h03);
		wr(2, 8);
		pls = 5'h04;
		tick(3 * H + 8);
		pls = 5'h00;
		tick(4);
		chk(cmd.run, 1'b1);
		// output freeze masks the plain stop, latched run survives
		wr(0, 15);
		wr(3, 6);
		hold(5'h01);
		chk({cmd.rampStop, cmd.run, cmd.freezeOut}, 3'h3);
		// up and down pulsed together: down wins
		wr(2, 17);
		pls = 5'h06;
		n = 0;
		c = 0;
		repeat (3 * H + 8) begin
			tick(1);
			n += stepDown;
			c += stepUp;
		end
		pls = 5'h00;
		chk({n[3:0], c[3:0]}, 8'h10);
		wr(4, 2);
		hold(5'h01);
		chk({cmd.coast, cmd.rampStop, cmd.run}, 3'h4);
		// pass-through functions
		for (i = 0; i < 5; i++) wr(i, 19 + i);
		hold(5'h1F);
		chk(aux[11:0], 12'h7C0);
		wr(0, 24);
		wr(1, 31);
		wr(2, 32);
		wr(3, 33);
		wr(4, 0);
		hold(5'h1F);
		chk(aux[11:0], 12'h039);
		chk(cmd.run, 1'b1);
		wr(0, 27);
		wr(1, 26);
		wr(2, 0);
		wr(3, 0);
		hold(5'h01);
		chk({aux[3:0], cmd.rampStop, cmd.run}, 6'h1A);
		hold(5'h03);
		chk({aux[3:0], cmd.rampStop, cmd.run}, 6'h09);
		closeOut();
	end
endmodule
